// ### inc/hbc_pkg.sv
// package for the hardware breakpoint comparator
// assumes one bus clock and the plain register port of the comparator
package hbc_pkg;

    // ****************************************
    // register offsets (byte registers)
    // ****************************************
    localparam logic [2:0] OFF_CONTROL_0 = 3'h0;
    localparam logic [2:0] OFF_CONTROL_1 = 3'h1;
    localparam logic [2:0] OFF_ADDRESS_HIGH = 3'h2;
    localparam logic [2:0] OFF_ADDRESS_LOW = 3'h3;
    localparam logic [2:0] OFF_DATA_HIGH = 3'h4;
    localparam logic [2:0] OFF_DATA_LOW = 3'h5;

    // ****************************************
    // field positions, control 0
    // ****************************************
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_BREAK_ON_PROGRAM = 5;
    localparam int BIT_SECOND_RANGE = 1;
    localparam int BIT_FIRST_RANGE = 0;

    // ****************************************
    // field positions, control 1
    // ****************************************
    localparam int BIT_DATA_BUS_ENABLE = 7;
    localparam int BIT_HIGH_MASK = 6;
    localparam int BIT_LOW_MASK = 5;
    localparam int BIT_SECOND_DIR_ENABLE = 3;
    localparam int BIT_SECOND_DIR_VALUE = 2;
    localparam int BIT_FIRST_DIR_ENABLE = 1;
    localparam int BIT_FIRST_DIR_VALUE = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_COMPARE = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ****************************************
    // modes and carriers
    // ****************************************
    typedef enum logic [1:0] {
        HBC_OFF = 2'h0,
        HBC_SWI_DUAL = 2'h1,
        HBC_BDM_FULL = 2'h2,
        HBC_BDM_DUAL = 2'h3
    } hbc_mode_t;

    typedef struct packed {
        logic valid;
        logic [15:0] address;
        logic [15:0] data;
        logic read;
        logic program_fetch;
    } hbc_bus_t;

    typedef struct packed {
        logic [2:0] address;
        logic [7:0] write_data;
        logic write;
        logic read;
    } hbc_reg_req_t;

endpackage : hbc_pkg

// ### hdl/hbc_compare.sv
// hardware breakpoint comparator: registers, match logic and requests
// assumes cpu bus cycles and debug status are synchronous to clk_sys
//
// How it works
// - mode bits: 00 off, 01 swi dual, 10 bdm full, 11 bdm dual
// - no match at all while background mode is active
// - swi dual: interrupt per address match, fetch-tagged only, no data
// - swi dual: per-breakpoint range bits; direction and masks ignored
// - dual modes: data-bus enable gates second address breakpoint
// - full mode ignores second range and direction bits
// - full mode: data enable and masks, ignored when break on program
// - bdm dual: program, range, direction honoured; masks ignored
// - debug entry only while debug enable is set
// - break on program zero: next boundary; one: executed opcode only
// - break on program has no effect in swi dual mode
// - first breakpoint: range clear high byte only, set full word
// - second breakpoint: range set adds low data register to low byte
// - data enable clear excludes both data registers everywhere
// - full mode: high mask drops 15:8, low mask drops 7:0
// - first direction: enable clear don't care, value 0 write 1 read
// - second direction in dual mode works like the first
// - address registers compare high and low address bytes
// - data registers: data bus in full, address bus in dual
// - compare registers cleared on power-on only
// - control registers readable and writable at any time
// - tagged fetch travels the queue, enters background at head in bdm modes
// - background mode never entered while debug enable is clear
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module hbc_compare
(
    // clock and resets
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic power_on_reset_n,
    // register port
    input wire hbc_pkg::hbc_reg_req_t reg_req,
    output logic [7:0] reg_read_data,
    // cpu bus and debug status
    input wire hbc_pkg::hbc_bus_t cpu_bus,
    input wire logic instruction_boundary,
    input wire logic tag_at_head,
    input wire logic background_active,
    input wire logic debug_enable,
    // requests
    output logic swi_request,
    output logic debug_entry_request,
    output logic fetch_tag
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] break_control_0;
    logic [7:0] break_control_1;
    logic [7:0] break_address_high;
    logic [7:0] break_address_low;
    logic [7:0] break_data_high;
    logic [7:0] break_data_low;

    // control registers follow ordinary reset
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            break_control_0 <= hbc_pkg::RESET_CONTROL;
            break_control_1 <= hbc_pkg::RESET_CONTROL;
        end
        else if (reg_req.write)
        begin
            if (reg_req.address == hbc_pkg::OFF_CONTROL_0)
                break_control_0 <= reg_req.write_data;
            if (reg_req.address == hbc_pkg::OFF_CONTROL_1)
                break_control_1 <= reg_req.write_data;
        end
    end

    // compare registers only see power-on reset, so a debugger's setup
    // survives watchdog and pin resets
    always_ff @(posedge clk_sys)
    begin
        if (!power_on_reset_n)
        begin
            break_address_high <= hbc_pkg::RESET_COMPARE;
            break_address_low <= hbc_pkg::RESET_COMPARE;
            break_data_high <= hbc_pkg::RESET_COMPARE;
            break_data_low <= hbc_pkg::RESET_COMPARE;
        end
        else if (reg_req.write)
        begin
            unique case (reg_req.address)
                hbc_pkg::OFF_ADDRESS_HIGH:
                    break_address_high <= reg_req.write_data;
                hbc_pkg::OFF_ADDRESS_LOW:
                    break_address_low <= reg_req.write_data;
                hbc_pkg::OFF_DATA_HIGH:
                    break_data_high <= reg_req.write_data;
                hbc_pkg::OFF_DATA_LOW:
                    break_data_low <= reg_req.write_data;
                default:
                begin
                end
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            reg_read_data <= hbc_pkg::READ_UNMAPPED;
        else if (!reg_req.read)
            reg_read_data <= hbc_pkg::READ_UNMAPPED;
        else
        begin
            unique case (reg_req.address)
                hbc_pkg::OFF_CONTROL_0:
                    reg_read_data <= break_control_0;
                hbc_pkg::OFF_CONTROL_1:
                    reg_read_data <= break_control_1;
                hbc_pkg::OFF_ADDRESS_HIGH:
                    reg_read_data <= break_address_high;
                hbc_pkg::OFF_ADDRESS_LOW:
                    reg_read_data <= break_address_low;
                hbc_pkg::OFF_DATA_HIGH:
                    reg_read_data <= break_data_high;
                hbc_pkg::OFF_DATA_LOW:
                    reg_read_data <= break_data_low;
                default:
                    reg_read_data <= hbc_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // ****************************************
    // field decode
    // ****************************************
    hbc_pkg::hbc_mode_t mode;
    logic break_on_program;
    logic first_range_control;
    logic second_range_control;
    logic data_bus_compare_enable;
    logic high_byte_mask;
    logic low_byte_mask;
    logic first_dir_compare_enable;
    logic first_dir_value;
    logic second_dir_compare_enable;
    logic second_dir_value;

    assign mode = hbc_pkg::hbc_mode_t'({
        break_control_0[hbc_pkg::BIT_MODE_HI],
        break_control_0[hbc_pkg::BIT_MODE_LO]});
    assign break_on_program = break_control_0[hbc_pkg::BIT_BREAK_ON_PROGRAM];
    assign first_range_control = break_control_0[hbc_pkg::BIT_FIRST_RANGE];
    assign second_range_control = break_control_0[hbc_pkg::BIT_SECOND_RANGE];
    assign data_bus_compare_enable =
        break_control_1[hbc_pkg::BIT_DATA_BUS_ENABLE];
    assign high_byte_mask = break_control_1[hbc_pkg::BIT_HIGH_MASK];
    assign low_byte_mask = break_control_1[hbc_pkg::BIT_LOW_MASK];
    assign first_dir_compare_enable =
        break_control_1[hbc_pkg::BIT_FIRST_DIR_ENABLE];
    assign first_dir_value = break_control_1[hbc_pkg::BIT_FIRST_DIR_VALUE];
    assign second_dir_compare_enable =
        break_control_1[hbc_pkg::BIT_SECOND_DIR_ENABLE];
    assign second_dir_value = break_control_1[hbc_pkg::BIT_SECOND_DIR_VALUE];

    // ****************************************
    // comparators
    // ****************************************
    // direction check: enable clear is don't care, value 1 matches reads
    function automatic logic dir_ok(input logic enable, input logic value,
                                    input logic is_read);
        dir_ok = !enable || (value == is_read);
    endfunction : dir_ok

    // byte address compare with optional low byte
    function automatic logic addr_ok(input logic [7:0] high,
                                     input logic [7:0] low,
                                     input logic use_low,
                                     input logic [15:0] address);
        addr_ok = (address[15:8] == high) &&
                  (!use_low || (address[7:0] == low));
    endfunction : addr_ok

    logic dual_mode;
    logic program_only;
    logic first_dir_match;
    logic second_dir_match;
    logic first_hit;
    logic second_hit;
    logic data_hit;
    logic any_hit;

    assign dual_mode = (mode == hbc_pkg::HBC_SWI_DUAL) ||
                       (mode == hbc_pkg::HBC_BDM_DUAL);
    // swi dual is always fetch-tagged, whatever break on program says
    assign program_only = (mode == hbc_pkg::HBC_SWI_DUAL) ||
                          break_on_program;

    // direction ignored in swi dual mode and for program breakpoints
    assign first_dir_match = program_only ||
        dir_ok(first_dir_compare_enable, first_dir_value,
               cpu_bus.read);
    assign second_dir_match = program_only ||
        dir_ok(second_dir_compare_enable, second_dir_value,
               cpu_bus.read);

    assign first_hit = addr_ok(break_address_high, break_address_low,
                               first_range_control,
                               cpu_bus.address) && first_dir_match;

    // second address breakpoint lives only in dual modes
    assign second_hit = dual_mode && data_bus_compare_enable &&
        addr_ok(break_data_high, break_data_low, second_range_control,
                cpu_bus.address) && second_dir_match;

    // full mode data compare; masks and enable drop out under program
    assign data_hit = !data_bus_compare_enable || break_on_program ||
        ((high_byte_mask || cpu_bus.data[15:8] == break_data_high) &&
         (low_byte_mask || cpu_bus.data[7:0] == break_data_low));

    always_comb
    begin
        any_hit = 1'b0;
        unique case (mode)
            hbc_pkg::HBC_OFF:
                any_hit = 1'b0;
            hbc_pkg::HBC_BDM_FULL:
                any_hit = first_hit && data_hit;
            hbc_pkg::HBC_SWI_DUAL,
            hbc_pkg::HBC_BDM_DUAL:
                any_hit = first_hit || second_hit;
        endcase
    end

    logic qualified;
    assign qualified = cpu_bus.valid && any_hit && !background_active &&
                       (!program_only || cpu_bus.program_fetch);

    // ****************************************
    // pending break and requests
    // ****************************************
    // a data break waits for the next instruction boundary; a program
    // break is tagged on the fetch and fires when the tag reaches the head
    logic data_pending;
    logic next_data_pending;
    logic bdm_mode;

    assign bdm_mode = mode == hbc_pkg::HBC_BDM_FULL ||
                      mode == hbc_pkg::HBC_BDM_DUAL;

    always_comb
    begin
        next_data_pending = data_pending;
        if (background_active || !bdm_mode || break_on_program)
            next_data_pending = 1'b0;
        else if (qualified)
            next_data_pending = 1'b1;
        else if (instruction_boundary)
            next_data_pending = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            data_pending <= 1'b0;
        else
            data_pending <= next_data_pending;
    end

    // tag the fetched opcode so the queue carries it to the head
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            fetch_tag <= 1'b0;
        else
            fetch_tag <= qualified && program_only;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            swi_request <= 1'b0;
        else
            swi_request <= mode == hbc_pkg::HBC_SWI_DUAL && tag_at_head &&
                           !background_active;
    end

    // no hardware stops a break without debug enable set; gating here
    // avoids the re-entry loop the debug firmware would otherwise run
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            debug_entry_request <= 1'b0;
        else
            debug_entry_request <= bdm_mode && debug_enable &&
                !background_active && !debug_entry_request &&
                ((data_pending && instruction_boundary) ||
                 (break_on_program && tag_at_head));
    end

    // ****************************************
    // checks
    // ****************************************
    property p_no_debug_without_enable;
        @(posedge clk_sys) disable iff (!reset_n)
        !debug_enable |=> !debug_entry_request;
    endproperty
    a_no_debug_without_enable: assert property (p_no_debug_without_enable)
        else $error("debug entry without debug enable");

    property p_no_match_in_background;
        @(posedge clk_sys) disable iff (!reset_n)
        background_active |=> !fetch_tag && !swi_request;
    endproperty
    a_no_match_in_background: assert property (p_no_match_in_background)
        else $error("match while background active");

    property p_swi_only_dual;
        @(posedge clk_sys) disable iff (!reset_n)
        swi_request |-> $past(mode) == hbc_pkg::HBC_SWI_DUAL;
    endproperty
    a_swi_only_dual: assert property (p_swi_only_dual)
        else $error("software interrupt outside swi dual mode");

    property p_off_quiet;
        @(posedge clk_sys) disable iff (!reset_n)
        mode == hbc_pkg::HBC_OFF |=> !fetch_tag;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("tag while breakpoints off");

    property p_one_request;
        @(posedge clk_sys) disable iff (!reset_n)
        !(swi_request && debug_entry_request);
    endproperty
    a_one_request: assert property (p_one_request)
        else $error("both requests at once");

    property p_debug_pulse;
        @(posedge clk_sys) disable iff (!reset_n)
        debug_entry_request |=> !debug_entry_request;
    endproperty
    a_debug_pulse: assert property (p_debug_pulse)
        else $error("debug request longer than one cycle");

    property p_tag_on_fetch;
        @(posedge clk_sys) disable iff (!reset_n)
        fetch_tag |-> $past(cpu_bus.program_fetch) && $past(cpu_bus.valid);
    endproperty
    a_tag_on_fetch: assert property (p_tag_on_fetch)
        else $error("tag on a non-fetch cycle");

    property p_first_full_addr;
        @(posedge clk_sys) disable iff (!reset_n)
        fetch_tag && $past(mode) == hbc_pkg::HBC_BDM_FULL &&
            $past(first_range_control) |->
        $past(cpu_bus.address) == {$past(break_address_high),
                                   $past(break_address_low)};
    endproperty
    a_first_full_addr: assert property (p_first_full_addr)
        else $error("full mode tag with wrong address");

    property p_control_readback;
        @(posedge clk_sys) disable iff (!reset_n)
        reg_req.read && reg_req.address == hbc_pkg::OFF_CONTROL_1 |=>
        reg_read_data == $past(break_control_1);
    endproperty
    a_control_readback: assert property (p_control_readback)
        else $error("control 1 read back wrong");

endmodule : hbc_compare

// ### test/hbc_cpu_model.sv
// cpu core and background debug unit model facing the comparator
// assumes the comparator samples all of these on the rising clk_sys edge
`timescale 1ns/1ps

module hbc_cpu_model
#(
    parameter int QUEUE_DELAY = 3,
    parameter int BOUNDARY_EVERY = 4
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // requests from the comparator
    input wire logic fetch_tag,
    input wire logic debug_entry_request,
    // cpu bus and debug status
    output hbc_pkg::hbc_bus_t cpu_bus,
    output logic instruction_boundary,
    output logic tag_at_head,
    output logic background_active,
    output logic debug_enable
);
    logic [QUEUE_DELAY-1:0] queue;
    int phase;

    initial
    begin
        cpu_bus = '0;
        instruction_boundary = 1'b0;
        tag_at_head = 1'b0;
        background_active = 1'b0;
        debug_enable = 1'b1;
    end

    // ****************************************
    // instruction flow
    // ****************************************
    always @(posedge clk_sys)
    begin
        if (!reset_n)
            phase <= 0;
        else
            phase <= (phase == BOUNDARY_EVERY - 1) ? 0 : phase + 1;
        instruction_boundary <= reset_n && (phase == BOUNDARY_EVERY - 1);
    end

    // tags are dropped on background entry, as the queue is flushed
    always @(posedge clk_sys)
    begin
        if (!reset_n || background_active)
            queue <= '0;
        else
            queue <= {queue[QUEUE_DELAY-2:0], fetch_tag};
        tag_at_head <= reset_n && !background_active && queue[QUEUE_DELAY-1];
    end

    always @(posedge clk_sys)
    begin
        if (!reset_n)
            background_active <= 1'b0;
        else if (debug_entry_request && debug_enable)
            background_active <= 1'b1;
    end

    // ****************************************
    // bus cycles and status control
    // ****************************************
    // released lines show the inverse, program fetch low, so stale values never match
    task bus_cycle(input logic [15:0] a, input logic [15:0] d,
                   input logic rd, input logic pf);
        @(posedge clk_sys);
        cpu_bus <= '{1'b1, a, d, rd, pf};
        @(posedge clk_sys);
        cpu_bus <= '{1'b0, ~a, ~d, ~rd, 1'b0};
    endtask : bus_cycle

    task set_background(input logic v);
        @(posedge clk_sys);
        background_active <= v;
    endtask : set_background

    task set_debug_enable(input logic v);
        @(posedge clk_sys);
        debug_enable <= v;
    endtask : set_debug_enable

endmodule : hbc_cpu_model

// ### test/hbc_compare_tb.sv
// self-checking bench for the breakpoint comparator
// assumes the cpu model drives the bus side; counts request pulses
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module hbc_compare_tb;
    logic clk_sys = 1'b0;
    logic reset_n;
    logic power_on_reset_n;
    hbc_pkg::hbc_reg_req_t reg_req;
    logic [7:0] reg_read_data;
    hbc_pkg::hbc_bus_t cpu_bus;
    logic instruction_boundary;
    logic tag_at_head;
    logic background_active;
    logic debug_enable;
    logic swi_request;
    logic debug_entry_request;
    logic fetch_tag;
    int n_fail = 0;
    int n_checks = 0;
    int n_swi = 0;
    int n_dbg = 0;
    int n_tag = 0;

    always #2.5 clk_sys = ~clk_sys;

    hbc_compare i_hbc_compare
    (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .power_on_reset_n(power_on_reset_n),
        .reg_req(reg_req), .reg_read_data(reg_read_data),
        .cpu_bus(cpu_bus), .instruction_boundary(instruction_boundary),
        .tag_at_head(tag_at_head), .background_active(background_active),
        .debug_enable(debug_enable), .swi_request(swi_request),
        .debug_entry_request(debug_entry_request), .fetch_tag(fetch_tag)
    );

    hbc_cpu_model i_hbc_cpu_model
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .fetch_tag(fetch_tag),
        .debug_entry_request(debug_entry_request), .cpu_bus(cpu_bus),
        .instruction_boundary(instruction_boundary),
        .tag_at_head(tag_at_head), .background_active(background_active),
        .debug_enable(debug_enable)
    );

    // a two-cycle pulse counts twice, so pulse width is checked too
    always @(posedge clk_sys)
    begin
        if (swi_request === 1'b1)
            n_swi <= n_swi + 1;
        if (debug_entry_request === 1'b1)
            n_dbg <= n_dbg + 1;
        if (fetch_tag === 1'b1)
            n_tag <= n_tag + 1;
    end

    // ****************************************
    // register port and scenario tasks
    // ****************************************
    task reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req.address <= a;
        reg_req.write_data <= d;
        reg_req.write <= 1'b1;
        @(posedge clk_sys);
        reg_req.write <= 1'b0;
    endtask : reg_write

    task reg_check(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_req.address <= a;
        reg_req.read <= 1'b1;
        @(posedge clk_sys);
        reg_req.read <= 1'b0;
        #1;
        `CHECK(reg_read_data, e)
    endtask : reg_check

    // expected nibbles: software interrupts, debug entries, fetch tags
    task vec(input logic [7:0] c0, input logic [7:0] c1,
             input logic [15:0] a, input logic [15:0] d,
             input logic rd, input logic pf, input logic [11:0] e);
        int b_swi;
        int b_dbg;
        int b_tag;
        logic [11:0] got;
        reg_write(hbc_pkg::OFF_CONTROL_0, c0);
        reg_write(hbc_pkg::OFF_CONTROL_1, c1);
        b_swi = n_swi;
        b_dbg = n_dbg;
        b_tag = n_tag;
        i_hbc_cpu_model.bus_cycle(a, d, rd, pf);
        repeat (16) @(posedge clk_sys);
        got = {4'(n_swi - b_swi), 4'(n_dbg - b_dbg), 4'(n_tag - b_tag)};
        `CHECK(got, e)
        i_hbc_cpu_model.set_background(1'b0);
    endtask : vec

    task report_and_stop;
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        reset_n <= 1'b0;
        power_on_reset_n <= 1'b0;
        reg_req <= '0;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        power_on_reset_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            reg_check(3'(i), (i < 2) ? hbc_pkg::RESET_CONTROL :
                      hbc_pkg::RESET_COMPARE);
        for (int i = 0; i < 6; i++)
        begin
            reg_write(3'(i), 8'hA1 + 8'(i));
            reg_check(3'(i), 8'hA1 + 8'(i));
        end
        reg_write(3'h6, 8'hFF);
        reg_check(3'h6, hbc_pkg::READ_UNMAPPED);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        @(posedge clk_sys);
        reset_n <= 1'b1;
        reg_check(hbc_pkg::OFF_CONTROL_0, hbc_pkg::RESET_CONTROL);
        reg_check(hbc_pkg::OFF_CONTROL_1, hbc_pkg::RESET_CONTROL);
        for (int i = 2; i < 6; i++)
            reg_check(3'(i), 8'hA1 + 8'(i));
        reg_write(hbc_pkg::OFF_ADDRESS_HIGH, 8'h12);
        reg_write(hbc_pkg::OFF_ADDRESS_LOW, 8'h34);
        reg_write(hbc_pkg::OFF_DATA_HIGH, 8'h56);
        reg_write(hbc_pkg::OFF_DATA_LOW, 8'h78);
        vec(8'h03, 8'h80, 16'h1234, 16'h5678, 1'b1, 1'b1, 12'h000);
        vec(8'h41, 8'h00, 16'h1234, 16'h0000, 1'b1, 1'b1, 12'h101);
        vec(8'h41, 8'h00, 16'h1234, 16'h0000, 1'b1, 1'b0, 12'h000);
        vec(8'h40, 8'h00, 16'h12FF, 16'h0000, 1'b1, 1'b1, 12'h101);
        vec(8'h41, 8'h00, 16'h12FF, 16'h0000, 1'b1, 1'b1, 12'h000);
        vec(8'h61, 8'h62, 16'h1234, 16'h0000, 1'b1, 1'b1, 12'h101);
        vec(8'h43, 8'h80, 16'h5678, 16'h0000, 1'b1, 1'b1, 12'h101);
        vec(8'h43, 8'h00, 16'h5678, 16'h0000, 1'b1, 1'b1, 12'h000);
        vec(8'h41, 8'h80, 16'h56AA, 16'h0000, 1'b1, 1'b1, 12'h101);
        vec(8'h43, 8'h80, 16'h56AA, 16'h0000, 1'b1, 1'b1, 12'h000);
        vec(8'h81, 8'h80, 16'h1234, 16'h5678, 1'b1, 1'b0, 12'h010);
        vec(8'h81, 8'h80, 16'h1234, 16'h5600, 1'b1, 1'b0, 12'h000);
        vec(8'h81, 8'hA0, 16'h1234, 16'h5600, 1'b1, 1'b0, 12'h010);
        vec(8'h81, 8'hC0, 16'h1234, 16'h0078, 1'b1, 1'b0, 12'h010);
        vec(8'h81, 8'h00, 16'h1234, 16'h0000, 1'b1, 1'b0, 12'h010);
        vec(8'h81, 8'h03, 16'h1234, 16'h0000, 1'b1, 1'b0, 12'h010);
        vec(8'h81, 8'h02, 16'h1234, 16'h0000, 1'b1, 1'b0, 12'h000);
        vec(8'h80, 8'h02, 16'h12AA, 16'h0000, 1'b0, 1'b0, 12'h010);
        vec(8'h83, 8'h8C, 16'h1234, 16'h5678, 1'b0, 1'b0, 12'h010);
        vec(8'h83, 8'h80, 16'h5678, 16'h5678, 1'b1, 1'b0, 12'h000);
        vec(8'hA1, 8'h80, 16'h1234, 16'h0000, 1'b1, 1'b1, 12'h011);
        vec(8'hA1, 8'h80, 16'h1234, 16'h0000, 1'b1, 1'b0, 12'h000);
        vec(8'hC3, 8'h80, 16'h5678, 16'h0000, 1'b1, 1'b0, 12'h010);
        vec(8'hC3, 8'h88, 16'h5678, 16'h0000, 1'b1, 1'b0, 12'h000);
        vec(8'hC3, 8'hEC, 16'h5678, 16'h0000, 1'b1, 1'b0, 12'h010);
        vec(8'hC1, 8'h02, 16'h1234, 16'h0000, 1'b1, 1'b0, 12'h000);
        vec(8'hE1, 8'h02, 16'h1234, 16'h0000, 1'b1, 1'b1, 12'h011);
        vec(8'hC3, 8'h00, 16'h5678, 16'h0000, 1'b1, 1'b0, 12'h000);
        i_hbc_cpu_model.set_debug_enable(1'b0);
        vec(8'h81, 8'h80, 16'h1234, 16'h5678, 1'b1, 1'b0, 12'h000);
        i_hbc_cpu_model.set_debug_enable(1'b1);
        i_hbc_cpu_model.set_background(1'b1);
        vec(8'hA1, 8'h80, 16'h1234, 16'h0000, 1'b1, 1'b1, 12'h000);
        i_hbc_cpu_model.set_background(1'b1);
        vec(8'h41, 8'h00, 16'h1234, 16'h0000, 1'b1, 1'b1, 12'h000);
        @(posedge clk_sys);
        power_on_reset_n <= 1'b0;
        @(posedge clk_sys);
        power_on_reset_n <= 1'b1;
        for (int i = 2; i < 6; i++)
            reg_check(3'(i), hbc_pkg::RESET_COMPARE);
        report_and_stop();
    end

endmodule : hbc_compare_tb
